// File: src/rpms_defs.svh
/*
  Constants of the receiver power and mode sequencer: timing, register map,
  field positions and reset values. Assumes a 10 MHz core clock.
*/
`ifndef RPMS_DEFS_SVH
`define RPMS_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPMS_CLK_MHZ         10
`define RPMS_CYC(us)         ((us) * `RPMS_CLK_MHZ)
`define RPMS_T_SHUT_US       10
`define RPMS_T_PWRUP_US      400
`define RPMS_T_XO_ON_US      380
`define RPMS_T_RX_ON_US      320
`define RPMS_T_RX_OFF_US     10
`define RPMS_T_XO_OFF_US     10
`define RPMS_T_WAIT_IN_US    10
`define RPMS_T_PRESET_US     700
`define RPMS_T_POLL_WAIT_US  1000
`define RPMS_T_POLL_DET_US   480
`define RPMS_CNT_W           14

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define RPMS_CTRL_ADDR       8'h14
`define RPMS_RXCFG_ADDR      8'h10
`define RPMS_STAT_ADDR       8'h15
`define RPMS_CTRL_RST        8'h00
`define RPMS_RXCFG_RST       8'h00
`define RPMS_XO_BIT          0
`define RPMS_RX_BIT          1
`define RPMS_WUT_BIT         2
// arbitrary device address
`define RPMS_I2C_ADDR        7'h2A
`define RPMS_BYTE_BITS       4'h8
`define RPMS_LOWBAND_LIM     4'h5

`endif

// File: src/rpms_pkg.sv
/*
  Types of the receiver power and mode sequencer.
  Assumes the three-level pins arrive already encoded by level detectors.
*/
package rpms_pkg;

  typedef enum logic [1:0] {
    TRI_GND  = 2'h0,
    TRI_OPEN = 2'h1,
    TRI_VDD  = 2'h2
  } rpms_tri_e;

  typedef enum logic [3:0] {
    PS_SHUTDOWN  = 4'h0,
    PS_POWERUP   = 4'h1,
    PS_SLEEP     = 4'h2,
    PS_XO_START  = 4'h3,
    PS_STANDBY   = 4'h4,
    PS_XO_STOP   = 4'h5,
    PS_RX_START  = 4'h6,
    PS_HOST_RX   = 4'h7,
    PS_RX_STOP   = 4'h8,
    PS_WAIT_IN   = 4'h9,
    PS_POLL_WAIT = 4'hA,
    PS_POLL_RX   = 4'hB,
    PS_PRESET_UP = 4'hC,
    PS_SHUT_IN   = 4'hD
  } rpms_pstate_e;

  typedef enum logic [2:0] {
    IS_IDLE  = 3'h0,
    IS_ADDR  = 3'h1,
    IS_REG   = 3'h2,
    IS_WDATA = 3'h3,
    IS_RDATA = 3'h4
  } rpms_i2c_e;

  typedef struct packed {
    logic       prog;
    logic [3:0] freq_sel;
    logic       low_rate;
    logic       if_400k;
    logic       ask_en;
    logic       fsk_en;
  } rpms_mode_s;

endpackage

// File: src/rpms_sequencer.sv
/*
  Power-state and mode sequencer of a sub-GHz receiver, with its I2C
  register slave. Assumes a 10 MHz clock, pins from outside the clock
  domain, and three-level pins delivered as codes by level detectors.
*/
`timescale 1ns/1ps
`include "rpms_defs.svh"

// Summary of operation
// - power-down high: shutdown, registers lost, no I2C
// - power-down high reaches shutdown in 10us
// - power-down low: supply on, sleep (preset: receive), registers default
// - oscillator bit: sleep/standby, 380us and 10us
// - receive bit from standby: receive in 320us
// - power control bits live at offset 0x14
// - receive-path writes ignored while receiver active
// - control writable in receive; clear: standby 10us
// - polling alternates wait and receive; entry 10us
// - select pin at supply: programming, else preset
// - preset: two select pins pick nine frequencies
// - preset: ground low-rate, open 400kHz IF
// - programming both keyings; preset one per variant
// - preset: only shutdown or receive, no wake timer
// - preset: release reaches receive in 700us
// - grounded power-down never reaches shutdown
// - operational transitions only by register bits
// - self-polling only in programming mode
module rpms_sequencer
  import rpms_pkg::*;
#(
  parameter int unsigned PRESET_CYC    = `RPMS_CYC(`RPMS_T_PRESET_US),
  parameter int unsigned POLL_WAIT_CYC = `RPMS_CYC(`RPMS_T_POLL_WAIT_US),
  parameter int unsigned POLL_DET_CYC  = `RPMS_CYC(`RPMS_T_POLL_DET_US),
  parameter bit          ASK_VARIANT   = 1'b1
) (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       power_down_pin_i,
  input  wire logic [1:0] iface_select_i,
  input  wire logic [1:0] preset_select_low_i,
  input  wire logic [1:0] preset_select_high_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output rpms_pstate_e    state_o,
  output logic            supply_on_o,
  output logic            osc_on_o,
  output logic            rx_on_o,
  output rpms_mode_s      mode_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_q;
  logic [1:0] bus_q;

  rpms_sync2 #(.WIDTH(7)) u_pin_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    // pin enters inverted so a cleared synchroniser reads as power-down held, no false release
    .d_i     ({!power_down_pin_i, iface_select_i, preset_select_high_i, preset_select_low_i}),
    .q_o     (pin_q)
  );
  rpms_sync2 #(.WIDTH(2)) u_bus_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     (bus_q)
  );

  localparam logic [`RPMS_CNT_W-1:0] CYC_SHUT  = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_SHUT_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_PWRUP = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_PWRUP_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_XO_ON = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_XO_ON_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_RX_ON = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_RX_ON_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_RXOFF = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_RX_OFF_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_XOOFF = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_XO_OFF_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_WAIT  = `RPMS_CNT_W'(`RPMS_CYC(`RPMS_T_WAIT_IN_US) - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_PRE   = `RPMS_CNT_W'(PRESET_CYC - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_PW    = `RPMS_CNT_W'(POLL_WAIT_CYC - 1);
  localparam logic [`RPMS_CNT_W-1:0] CYC_PD    = `RPMS_CNT_W'(POLL_DET_CYC - 1);
  localparam int                     RXOFF_DLY = `RPMS_CYC(`RPMS_T_RX_OFF_US);

  logic       pd_s;
  rpms_tri_e  if_s;
  rpms_tri_e  hi_s;
  rpms_tri_e  lo_s;
  assign pd_s = !pin_q[6];
  assign if_s = rpms_tri_e'(pin_q[5:4]);
  assign hi_s = rpms_tri_e'(pin_q[3:2]);
  assign lo_s = rpms_tri_e'(pin_q[1:0]);

  // ----------------------------------------------------------------
  // power state machine and registers
  // ----------------------------------------------------------------
  rpms_pstate_e            state_r, state_nxt;
  logic [`RPMS_CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [`RPMS_CNT_W-1:0]  dwell_r, dwell_nxt;
  logic [7:0]              ctrl_r, ctrl_nxt;
  logic [7:0]              rxcfg_r, rxcfg_nxt;
  rpms_mode_s              mode_r, mode_nxt;
  logic                    sup_nxt, osc_nxt, rxon_nxt;
  logic                    wstb_r;
  logic [7:0]              waddr_r, wdata_r;
  rpms_mode_s              dec;
  logic                    done;
  logic                    rx_active;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - `RPMS_CNT_W'(1) : cnt_r;
    ctrl_nxt  = ctrl_r;
    rxcfg_nxt = rxcfg_r;
    mode_nxt  = mode_r;
    done      = (cnt_r == '0);
    rx_active = (state_r == PS_RX_START) || (state_r == PS_HOST_RX) || (state_r == PS_POLL_RX);
    dec.prog      = (if_s == TRI_VDD);
    dec.freq_sel  = 4'({2'h0, hi_s} + {2'h0, hi_s} + {2'h0, hi_s} + {2'h0, lo_s});
    dec.low_rate  = (if_s == TRI_GND);
    dec.if_400k   = !(dec.low_rate && (dec.freq_sel < `RPMS_LOWBAND_LIM));
    dec.ask_en    = dec.prog || ASK_VARIANT;
    dec.fsk_en    = dec.prog || !ASK_VARIANT;
    if (wstb_r) begin
      if (waddr_r == `RPMS_CTRL_ADDR) begin
        ctrl_nxt = wdata_r;
      end else if (waddr_r == `RPMS_RXCFG_ADDR && !rx_active) begin
        rxcfg_nxt = wdata_r;
      end
    end
    case (state_r)
      PS_SHUTDOWN: begin
        ctrl_nxt  = `RPMS_CTRL_RST;
        rxcfg_nxt = `RPMS_RXCFG_RST;
        if (!pd_s) begin
          mode_nxt = dec;
          if (dec.prog) begin
            state_nxt = PS_POWERUP;
            cnt_nxt   = CYC_PWRUP;
          end else begin
            state_nxt = PS_PRESET_UP;
            cnt_nxt   = CYC_PRE;
          end
        end
      end
      PS_POWERUP: if (done) state_nxt = PS_SLEEP;
      PS_SLEEP: begin
        if (ctrl_r[`RPMS_XO_BIT]) begin
          state_nxt = PS_XO_START;
          cnt_nxt   = CYC_XO_ON;
        end
      end
      PS_XO_START: if (done) state_nxt = PS_STANDBY;
      PS_STANDBY: begin
        if (!ctrl_r[`RPMS_XO_BIT]) begin
          state_nxt = PS_XO_STOP;
          cnt_nxt   = CYC_XOOFF;
        end else if (ctrl_r[`RPMS_WUT_BIT]) begin
          state_nxt = PS_WAIT_IN;
          cnt_nxt   = CYC_WAIT;
        end else if (ctrl_r[`RPMS_RX_BIT]) begin
          state_nxt = PS_RX_START;
          cnt_nxt   = CYC_RX_ON;
        end
      end
      PS_XO_STOP: if (done) state_nxt = PS_SLEEP;
      PS_RX_START: if (done) state_nxt = PS_HOST_RX;
      PS_HOST_RX: begin
        // preset parts have no serial port, so receive is held by the pin
        if (mode_r.prog && !ctrl_r[`RPMS_RX_BIT]) begin
          state_nxt = PS_RX_STOP;
          cnt_nxt   = CYC_RXOFF;
        end
      end
      PS_RX_STOP: if (done) state_nxt = PS_STANDBY;
      PS_WAIT_IN: begin
        if (done) begin
          state_nxt = PS_POLL_WAIT;
          cnt_nxt   = CYC_PW;
        end
      end
      PS_POLL_WAIT: begin
        if (!ctrl_r[`RPMS_WUT_BIT]) begin
          state_nxt = PS_STANDBY;
        end else if (done) begin
          state_nxt = PS_POLL_RX;
          cnt_nxt   = CYC_PD;
        end
      end
      PS_POLL_RX: begin
        if (!ctrl_r[`RPMS_WUT_BIT]) begin
          state_nxt = PS_STANDBY;
        end else if (done) begin
          state_nxt = PS_POLL_WAIT;
          cnt_nxt   = CYC_PW;
        end
      end
      PS_PRESET_UP: if (done) state_nxt = PS_HOST_RX;
      PS_SHUT_IN: if (done) state_nxt = PS_SHUTDOWN;
      default: state_nxt = PS_SHUTDOWN;
    endcase
    // only a high pin leads to shutdown; a grounded pin never gets there
    if (pd_s && state_r != PS_SHUTDOWN && state_r != PS_SHUT_IN) begin
      state_nxt = PS_SHUT_IN;
      cnt_nxt   = CYC_SHUT;
    end
    dwell_nxt = (state_nxt != state_r) ? '0 : dwell_r + `RPMS_CNT_W'(1);
    sup_nxt   = (state_nxt != PS_SHUTDOWN);
    osc_nxt   = !(state_nxt inside {PS_SHUTDOWN, PS_POWERUP, PS_SLEEP, PS_SHUT_IN});
    rxon_nxt  = (state_nxt == PS_HOST_RX) || (state_nxt == PS_POLL_RX);
  end

  // shutdown is the power-on state of the core
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_r     <= PS_SHUTDOWN;
      cnt_r       <= '0;
      dwell_r     <= '0;
      ctrl_r      <= `RPMS_CTRL_RST;
      rxcfg_r     <= `RPMS_RXCFG_RST;
      mode_r      <= '0;
      supply_on_o <= 1'b0;
      osc_on_o    <= 1'b0;
      rx_on_o     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      dwell_r     <= dwell_nxt;
      ctrl_r      <= ctrl_nxt;
      rxcfg_r     <= rxcfg_nxt;
      mode_r      <= mode_nxt;
      supply_on_o <= sup_nxt;
      osc_on_o    <= osc_nxt;
      rx_on_o     <= rxon_nxt;
    end
  end

  assign state_o = state_r;
  assign mode_o  = mode_r;

  // ----------------------------------------------------------------
  // I2C register slave
  // ----------------------------------------------------------------
  rpms_i2c_e  i_r, i_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic       ack_r, ack_nxt;
  logic       oe_nxt;
  logic       scl_d_r, sda_d_r;
  logic       wstb_nxt;
  logic [7:0] waddr_nxt, wdata_nxt;
  logic [7:0] rdata;
  logic       rise, fall, start, stop, serial_ok;

  always_comb begin
    i_nxt     = i_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    ptr_nxt   = ptr_r;
    ack_nxt   = ack_r;
    oe_nxt    = sda_oe_o;
    wstb_nxt  = 1'b0;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    rise      = bus_q[1] && !scl_d_r;
    fall      = !bus_q[1] && scl_d_r;
    start     = bus_q[1] && scl_d_r && sda_d_r && !bus_q[0];
    stop      = bus_q[1] && scl_d_r && !sda_d_r && bus_q[0];
    serial_ok = mode_r.prog && (state_r != PS_SHUTDOWN) && (state_r != PS_SHUT_IN);
    case (ptr_r)
      `RPMS_CTRL_ADDR:  rdata = ctrl_r;
      `RPMS_RXCFG_ADDR: rdata = rxcfg_r;
      `RPMS_STAT_ADDR:  rdata = {4'h0, state_r};
      default:          rdata = 8'h00;
    endcase
    if (!serial_ok) begin
      i_nxt   = IS_IDLE;
      ack_nxt = 1'b0;
      oe_nxt  = 1'b0;
    end else if (start) begin
      i_nxt   = IS_ADDR;
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
      oe_nxt  = 1'b0;
    end else if (stop) begin
      i_nxt   = IS_IDLE;
      ack_nxt = 1'b0;
      oe_nxt  = 1'b0;
    end else if (i_r != IS_IDLE && rise) begin
      if (ack_r) begin
        if (i_r == IS_RDATA && bus_q[0]) i_nxt = IS_IDLE;
      end else begin
        bit_nxt = bit_r + 4'h1;
        sh_nxt  = (i_r == IS_RDATA) ? {sh_r[6:0], 1'b0} : {sh_r[6:0], bus_q[0]};
      end
    end else if (i_r != IS_IDLE && fall) begin
      if (ack_r) begin
        ack_nxt = 1'b0;
        oe_nxt  = 1'b0;
        bit_nxt = 4'h0;
        if (i_r == IS_RDATA) begin
          sh_nxt = rdata;
          oe_nxt = !rdata[7];
        end
      end else if (bit_r == `RPMS_BYTE_BITS) begin
        ack_nxt = 1'b1;
        oe_nxt  = 1'b1;
        case (i_r)
          IS_ADDR: begin
            if (sh_r[7:1] == `RPMS_I2C_ADDR) begin
              i_nxt = sh_r[0] ? IS_RDATA : IS_REG;
            end else begin
              i_nxt   = IS_IDLE;
              ack_nxt = 1'b0;
              oe_nxt  = 1'b0;
            end
          end
          IS_REG: begin
            ptr_nxt = sh_r;
            i_nxt   = IS_WDATA;
          end
          IS_WDATA: begin
            wstb_nxt  = 1'b1;
            waddr_nxt = ptr_r;
            wdata_nxt = sh_r;
            ptr_nxt   = ptr_r + 8'h01;
          end
          IS_RDATA: begin
            oe_nxt  = 1'b0;
            ptr_nxt = ptr_r + 8'h01;
          end
          default: i_nxt = IS_IDLE;
        endcase
      end else if (i_r == IS_RDATA) begin
        oe_nxt = !sh_r[7];
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      i_r      <= IS_IDLE;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      ptr_r    <= 8'h00;
      ack_r    <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      wstb_r   <= 1'b0;
      waddr_r  <= 8'h00;
      wdata_r  <= 8'h00;
    end else begin
      i_r      <= i_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      ptr_r    <= ptr_nxt;
      ack_r    <= ack_nxt;
      sda_oe_o <= oe_nxt;
      sda_o    <= 1'b0;
      scl_d_r  <= bus_q[1];
      sda_d_r  <= bus_q[0];
      wstb_r   <= wstb_nxt;
      waddr_r  <= waddr_nxt;
      wdata_r  <= wdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pd_enter: assert property (@(posedge clock_i) disable iff (reset_i)
    pd_s && !(state_r inside {PS_SHUTDOWN, PS_SHUT_IN}) |=> state_r == PS_SHUT_IN)
    else $error("power-down did not start shutdown");
  a_shut_time: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_SHUTDOWN && $past(state_r) == PS_SHUT_IN |-> $past(dwell_r) == CYC_SHUT)
    else $error("shutdown entry time wrong");
  a_shut_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_POWERUP && $past(state_r) == PS_SHUTDOWN |-> ctrl_r == `RPMS_CTRL_RST && rxcfg_r == `RPMS_RXCFG_RST)
    else $error("registers not at default after release");
  a_xo_time: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_STANDBY && $past(state_r) == PS_XO_START |-> $past(dwell_r) == CYC_XO_ON)
    else $error("oscillator start time wrong");
  a_rx_time: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_HOST_RX && $past(state_r) == PS_RX_START |-> $past(dwell_r) == CYC_RX_ON && rx_on_o)
    else $error("receive start time wrong");
  a_rx_cfg_lock: assert property (@(posedge clock_i) disable iff (reset_i)
    rx_active && wstb_r && waddr_r == `RPMS_RXCFG_ADDR |=> $stable(rxcfg_r))
    else $error("receive config written while active");
  a_rx_stop: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_HOST_RX && mode_r.prog && !ctrl_r[`RPMS_RX_BIT] && !pd_s
      |=> state_r == PS_RX_STOP ##RXOFF_DLY state_r == PS_STANDBY)
    else $error("receive stop sequence wrong");
  a_wait_time: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_POLL_WAIT && $past(state_r) == PS_WAIT_IN |-> $past(dwell_r) == CYC_WAIT)
    else $error("wait entry time wrong");
  a_preset_poll: assert property (@(posedge clock_i) disable iff (reset_i)
    !mode_r.prog |-> !(state_r inside {PS_WAIT_IN, PS_POLL_WAIT, PS_POLL_RX, PS_SLEEP, PS_STANDBY}))
    else $error("preset part left its two states");
  a_preset_time: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r == PS_HOST_RX && $past(state_r) == PS_PRESET_UP |-> $past(dwell_r) == CYC_PRE)
    else $error("preset start time wrong");
  a_mode_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    state_r != PS_SHUTDOWN && $past(state_r) != PS_SHUTDOWN |-> $stable(mode_r))
    else $error("mode changed while powered");

endmodule // rpms_sequencer

// File: src/rpms_sync2.sv
/*
  Two flip-flop synchroniser for a group of asynchronous levels.
  Assumes each bit is an independent level; no bus coherency is given.
*/
`timescale 1ns/1ps
module rpms_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // rpms_sync2

// File: tb/rpms_host.sv
/*
  Host model: drives the power-down pin and bit-bangs I2C at 1/16 clock.
  Assumes SDA is wired-and with a pull-up outside; SCL is pushed by the host.
*/
`timescale 1ns/1ps
`include "rpms_defs.svh"
module rpms_host (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      power_down_pin_o,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    power_down_pin_o = 1'b1;
    scl_o            = 1'b1;
    sda_pull_o       = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // pin always driven hard, never left floating
  task automatic power_cycle();
    power_down_pin_o = 1'b1;
    tick(10000);
    power_down_pin_o = 1'b0;
  endtask
  task automatic pd_high();
    power_down_pin_o = 1'b1;
  endtask
  // also serves as repeated start
  task automatic start();
    tick(4);
    sda_pull_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_pull_o = 1'b1;
    tick(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    sda_pull_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_pull_o = 1'b0;
    tick(8);
  endtask
  // eight bits then the ack slot, sampled late in scl high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(4);
      sda_pull_o = !tx[i];
      tick(4);
      scl_o = 1'b1;
      tick(6);
      rx[i] = sda_i;
      tick(2);
      scl_o = 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    xfer({`RPMS_I2C_ADDR, 1'b0, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop();
    ok = !(r0[0] || r1[0] || r2[0]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({`RPMS_I2C_ADDR, 1'b0, 1'b1}, r);
    xfer({a, 1'b1}, r);
    start();
    xfer({`RPMS_I2C_ADDR, 1'b1, 1'b1}, r);
    xfer(9'h1FF, r);
    stop();
    d = r[8:1];
  endtask
endmodule // rpms_host

// File: tb/rpms_sequencer_bench.sv
/*
  Self-checking bench of the power and mode sequencer.
  Assumes the host model above; timing windows allow a few cycles of slack.
*/
`timescale 1ns/1ps
`include "rpms_defs.svh"
module rpms_sequencer_bench;
  import rpms_pkg::*;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         pd, scl, pull, sda_oe, sda_out, supply, osc, rx, ok;
  logic [1:0]   iface = 2'h2;
  logic [1:0]   sel_lo = 2'h0;
  logic [1:0]   sel_hi = 2'h0;
  logic [7:0]   d;
  rpms_pstate_e state;
  rpms_mode_s   mode;
  wire          sda_w;
  int           errors = 0;
  int           samples_checked = 0;
  // ----------------------------------------------------------------
  // clock, wiring
  // ----------------------------------------------------------------
  always #50 clock = !clock;
  assign sda_w = !(pull || (sda_oe && !sda_out));
  rpms_host host (.clock_i(clock), .sda_i(sda_w), .power_down_pin_o(pd), .scl_o(scl), .sda_pull_o(pull));
  rpms_sequencer #(.PRESET_CYC(50), .POLL_WAIT_CYC(40), .POLL_DET_CYC(30), .ASK_VARIANT(1'b1)) DUT (
    .clock_i(clock), .reset_i(reset), .power_down_pin_i(pd), .iface_select_i(iface),
    .preset_select_low_i(sel_lo), .preset_select_high_i(sel_hi), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .state_o(state), .supply_on_o(supply), .osc_on_o(osc),
    .rx_on_o(rx), .mode_o(mode));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait; a too-early arrival fails as well
  task automatic wait_st(input rpms_pstate_e st, input int lo, input int hi);
    int n;
    n = 0;
    while (state !== st && n < hi) begin
      @(negedge clock);
      n++;
    end
    check({15'h0, n >= lo && state === st}, 16'h1);
  endtask
  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_prog_up();
    iface = 2'h2;
    host.power_cycle();
    wait_st(PS_POWERUP, 1, 4);
    check({15'h0, supply}, 16'h1);
    wait_st(PS_SLEEP, 3990, 4010);
    check({13'h0, mode.prog, mode.ask_en, mode.fsk_en}, 16'h7);
    host.rd(`RPMS_CTRL_ADDR, d);
    check({8'h0, d}, {8'h0, `RPMS_CTRL_RST});
    host.rd(`RPMS_RXCFG_ADDR, d);
    check({8'h0, d}, {8'h0, `RPMS_RXCFG_RST});
  endtask
  task automatic t_prog_run();
    host.wr(`RPMS_CTRL_ADDR, 8'h01, ok);
    wait_st(PS_STANDBY, 3700, 3810);
    check({14'h0, osc, rx}, 16'h2);
    host.wr(`RPMS_RXCFG_ADDR, 8'h5A, ok);
    check({15'h0, ok}, 16'h1);
    host.rd(`RPMS_STAT_ADDR, d);
    check({8'h0, d}, {12'h0, PS_STANDBY});
    host.wr(`RPMS_CTRL_ADDR, 8'h03, ok);
    wait_st(PS_HOST_RX, 3100, 3210);
    check({15'h0, rx}, 16'h1);
    host.wr(`RPMS_RXCFG_ADDR, 8'hA5, ok);
    host.rd(`RPMS_RXCFG_ADDR, d);
    check({8'h0, d}, 16'h005A);
    host.wr(`RPMS_CTRL_ADDR, 8'h01, ok);
    wait_st(PS_STANDBY, 0, 110);
    check({15'h0, rx}, 16'h0);
    host.wr(`RPMS_CTRL_ADDR, 8'h05, ok);
    wait_st(PS_POLL_WAIT, 60, 120);
    wait_st(PS_POLL_RX, 30, 50);
    check({15'h0, rx}, 16'h1);
    wait_st(PS_POLL_WAIT, 20, 40);
    host.wr(`RPMS_CTRL_ADDR, 8'h01, ok);
    wait_st(PS_STANDBY, 0, 20);
    host.wr(`RPMS_CTRL_ADDR, 8'h00, ok);
    wait_st(PS_SLEEP, 60, 110);
    host.pd_high();
    wait_st(PS_SHUT_IN, 1, 5);
    wait_st(PS_SHUTDOWN, 90, 110);
    check({15'h0, supply}, 16'h0);
    host.wr(`RPMS_CTRL_ADDR, 8'h01, ok);
    check({15'h0, ok}, 16'h0);
  endtask
  // pins are changed after release; the decoded mode must not follow them
  task automatic t_preset(input logic [1:0] ifc, input logic [1:0] hi, input logic [1:0] lo,
                          input logic [8:0] exp);
    iface  = ifc;
    sel_hi = hi;
    sel_lo = lo;
    host.power_cycle();
    wait_st(PS_PRESET_UP, 1, 4);
    wait_st(PS_HOST_RX, 40, 60);
    check({7'h0, mode}, {7'h0, exp});
    iface  = 2'h2;
    sel_hi = 2'h2;
    host.wr(`RPMS_CTRL_ADDR, 8'h00, ok);
    check({15'h0, ok}, 16'h0);
    check({12'h0, state}, {12'h0, PS_HOST_RX});
    check({7'h0, mode}, {7'h0, exp});
  endtask
  initial begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    t_prog_up();
    t_prog_run();
    t_prog_up();
    t_preset(2'h0, 2'h1, 2'h1, {1'b0, 4'h4, 1'b1, 1'b0, 1'b1, 1'b0});
    t_preset(2'h1, 2'h2, 2'h0, {1'b0, 4'h6, 1'b0, 1'b1, 1'b1, 1'b0});
    print_verdict();
  end
  initial begin
    #10_000_000;
    errors++;
    print_verdict();
  end
endmodule // rpms_sequencer_bench
